//--- rcc_consts.svh
`ifndef RCC_CONSTS_SVH
`define RCC_CONSTS_SVH
// ****************************************
// Timing
// ****************************************
`define RCC_CLK_HZ 125000000
`define RCC_WARM_MS 40
`define RCC_SRC_HZ 80000
`define RCC_SXT_HZ 32768
`define RCC_FRC_HZ 18432000
`define RCC_FXT_HZ 16000000
`define RCC_WDT_MIN_MS 50
`define RCC_PIN_TICKS 2'h2
`define RCC_DIV_W 12
`define RCC_WDT_W 16
`define RCC_WARM_W 24
// ****************************************
// Addresses
// ****************************************
`define RCC_A_PWR 16'h0087
`define RCC_A_OPT 16'h0094
`define RCC_A_IFLG 16'h0095
`define RCC_A_SOFTWARE_COMMAND_PORT 16'h0097
`define RCC_A_SYSTEM_CLOCK_CONTROL 16'h00D8
`define RCC_A_TRIM 16'h00F6
`define RCC_A_AUXB 16'h00F7
`define RCC_A_AUXA 16'h00F8
`define RCC_A_CFGH 16'h7FFF
// ****************************************
// Values and fields
// ****************************************
`define RCC_SW_KEY 8'h56
`define RCC_LVD_KEY 8'h7F
`define RCC_SYSTEM_CLOCK_CONTROL_RST 8'h23
`define RCC_OPT_MASK 8'hBF
`define RCC_PWR_MASK 8'h03
`define RCC_CFG_PINDIS 6
`define RCC_CFG_LVR 5:3
`define RCC_WDT_PER 5:4
`define RCC_WDT_EN 7:6
`define RCC_WDT_CLR 7
`define RCC_LVR_OFF 3
`define RCC_PWRSAV 5
`define RCC_LVD_FLAG 7
`define RCC_PD 1
`define RCC_IDL 0
`define RCC_WATCHDOG_RESET_ENABLE_ALWAYS 2'h3
`define RCC_WATCHDOG_RESET_ENABLE_RUN 2'h2
`endif

//--- rcc_pkg.sv
package rcc_pkg;
  typedef enum logic [1:0] {
    RCC_WARM = 2'h0,
    RCC_LOAD = 2'h1,
    RCC_RUN = 2'h3
  } rcc_state_e;
  typedef struct packed {
    logic slow_type;
    logic fast_type;
    logic slow_stop;
    logic periph_stop;
    logic fast_stop;
    logic fast_sel;
    logic [1:0] div;
  } rcc_system_clock_control_s;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rcc_bus_s;
endpackage

//--- rcc_reset_clock_ctrl.sv
// Local design decision: the strobed register port.
`include "rcc_consts.svh"
module rcc_reset_clock_ctrl import rcc_pkg::*; #(
  parameter int WARM_CYC = `RCC_CLK_HZ / 1000 * `RCC_WARM_MS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire rcc_bus_s bus,
  output logic [7:0] rdata,
  input wire logic ext_reset_n,
  input wire logic low_voltage_trip,
  input wire logic low_voltage_detect,
  input wire logic wakeup,
  input wire logic [7:0] boot_config_high_byte,
  input wire logic [6:0] trim_cal,
  output logic sys_reset,
  output logic sys_clk_en,
  output logic periph_clk_en,
  output logic fast_osc_on,
  output logic slow_osc_on,
  output rcc_system_clock_control_s clk_cfg,
  output logic [6:0] fast_rc_trim_value,
  output logic low_voltage_reset_on,
  output logic [2:0] low_voltage_reset_level,
  output logic idle_mode,
  output logic power_down_request
);
  // ****************************************
  // Oscillator time bases
  // ****************************************
  localparam int OSC_N = 4;
  localparam int OSC_DIV [OSC_N] = '{
    `RCC_CLK_HZ / `RCC_SRC_HZ, `RCC_CLK_HZ / `RCC_SXT_HZ,
    `RCC_CLK_HZ / `RCC_FRC_HZ, `RCC_CLK_HZ / `RCC_FXT_HZ};
  localparam int WDT_BASE = `RCC_SRC_HZ / 1000 * `RCC_WDT_MIN_MS;
  logic [OSC_N-1:0] osc_tick;
  genvar g;
  for (g = 0; g < OSC_N; g++) begin : g_osc
    logic [`RCC_DIV_W-1:0] cnt_reg;
    wire wrap = cnt_reg == `RCC_DIV_W'(OSC_DIV[g] - 1);
    always_ff @(posedge ref_clk) begin
      if (rst || wrap) begin
        cnt_reg <= '0;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
    assign osc_tick[g] = wrap;
  end
  wire src_tick = osc_tick[0];
  // ****************************************
  // Registers and state
  // ****************************************
  rcc_state_e state_reg;
  logic [`RCC_WARM_W-1:0] warm_reg;
  logic [7:0] cfg_reg, opt_reg, auxa_reg, auxb_reg, pwr_reg;
  logic lvd_flag_reg, rst_evt_reg;
  logic [1:0] pin_cnt_reg, eff_div_reg;
  logic [3:0] pre_reg;
  logic [`RCC_WDT_W-1:0] wdt_reg;
  rcc_system_clock_control_s cc_reg, cc_next;
  logic [6:0] trim_reg;
  logic [7:0] rd_reg;
  logic sys_rst_reg, sys_en_reg, per_en_reg, fast_on_reg, slow_on_reg;
  logic lvr_on_reg;
  // ****************************************
  // Decode
  // ****************************************
  wire run = state_reg == RCC_RUN;
  wire wr_pwr = bus.wr && bus.addr == `RCC_A_PWR;
  wire wr_opt = bus.wr && bus.addr == `RCC_A_OPT;
  wire wr_iflg = bus.wr && bus.addr == `RCC_A_IFLG;
  wire wr_sw = bus.wr && bus.addr == `RCC_A_SOFTWARE_COMMAND_PORT;
  wire wr_cc = bus.wr && bus.addr == `RCC_A_SYSTEM_CLOCK_CONTROL;
  wire wr_trim = bus.wr && bus.addr == `RCC_A_TRIM;
  wire wr_auxb = bus.wr && bus.addr == `RCC_A_AUXB;
  wire wr_auxa = bus.wr && bus.addr == `RCC_A_AUXA;
  wire pd = pwr_reg[`RCC_PD];
  wire idl = pwr_reg[`RCC_IDL];
  // ****************************************
  // Reset sources
  // ****************************************
  wire pin_hit = pin_cnt_reg == `RCC_PIN_TICKS && !cfg_reg[`RCC_CFG_PINDIS];
  wire sw_hit = wr_sw && bus.wdata == `RCC_SW_KEY;
  wire lvr_live = !auxa_reg[`RCC_LVR_OFF] && !(auxb_reg[`RCC_PWRSAV] && (idl || pd));
  wire lv_hit = low_voltage_trip && lvr_live;
  wire [1:0] watchdog_reset_enable = auxb_reg[`RCC_WDT_EN];
  wire wdt_arm = watchdog_reset_enable == `RCC_WATCHDOG_RESET_ENABLE_ALWAYS || (watchdog_reset_enable == `RCC_WATCHDOG_RESET_ENABLE_RUN && !idl && !pd);
  wire slow_alive = !(pd && cc_reg.slow_stop);
  wire wdt_step = src_tick && slow_alive && (wdt_arm || !(idl || pd));
  wire [1:0] wper = opt_reg[`RCC_WDT_PER];
  wire [`RCC_WDT_W-1:0] wdt_last = `RCC_WDT_W'((WDT_BASE << (2'h3 - wper)) - 1);
  wire wdt_hit = wdt_step && wdt_reg == wdt_last && wdt_arm;
  wire src_hit = pin_hit || sw_hit || lv_hit || wdt_hit;
  wire sfr_clr = rst || !run || rst_evt_reg;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= RCC_WARM;
      warm_reg <= '0;
    end else begin
      unique case (state_reg)
        RCC_WARM: begin
          warm_reg <= warm_reg + 1'b1;
          if (warm_reg == `RCC_WARM_W'(WARM_CYC - 1)) begin
            state_reg <= RCC_LOAD;
          end
        end
        RCC_LOAD: state_reg <= RCC_RUN;
        RCC_RUN: state_reg <= RCC_RUN;
        default: state_reg <= RCC_WARM;
      endcase
    end
  end
  // Config and trim are captured only at power-on, soft resets keep them
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg_reg <= '0;
      trim_reg <= '0;
    end else if (state_reg == RCC_LOAD) begin
      cfg_reg <= boot_config_high_byte;
      trim_reg <= trim_cal;
    end else if (wr_trim) begin
      trim_reg <= bus.wdata[6:0];
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst || ext_reset_n) begin
      pin_cnt_reg <= '0;
    end else if (src_tick && pin_cnt_reg != `RCC_PIN_TICKS) begin
      pin_cnt_reg <= pin_cnt_reg + 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    rst_evt_reg <= !rst && run && src_hit;
  end
  // ****************************************
  // Watchdog
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (sfr_clr || auxa_reg[`RCC_WDT_CLR]) begin
      wdt_reg <= '0;
    end else if (wdt_step) begin
      wdt_reg <= wdt_reg == wdt_last ? '0 : wdt_reg + 1'b1;
    end
  end
  // ****************************************
  // Control registers
  // ****************************************
  rcc_system_clock_control_s cw;
  assign cw = bus.wdata;
  wire cc_bad = cw.fast_stop && cw.fast_sel;
  assign cc_next.slow_type = cc_reg.fast_sel ? cw.slow_type : cc_reg.slow_type;
  assign cc_next.fast_type = !cc_reg.fast_sel ? cw.fast_type : cc_reg.fast_type;
  assign cc_next.slow_stop = cw.slow_stop;
  assign cc_next.periph_stop = cw.periph_stop;
  assign cc_next.fast_stop = !cc_reg.fast_sel ? cw.fast_stop : cc_reg.fast_stop;
  assign cc_next.fast_sel = !cc_reg.fast_stop ? cw.fast_sel : cc_reg.fast_sel;
  assign cc_next.div = cw.div;
  always_ff @(posedge ref_clk) begin
    if (sfr_clr) begin
      cc_reg <= `RCC_SYSTEM_CLOCK_CONTROL_RST;
    end else if (wr_cc && !cc_bad) begin
      cc_reg <= cc_next;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sfr_clr) begin
      opt_reg <= '0;
      auxb_reg <= '0;
    end else begin
      if (wr_opt) begin
        opt_reg <= bus.wdata & `RCC_OPT_MASK;
      end
      if (wr_auxb) begin
        auxb_reg <= bus.wdata;
      end
    end
  end
  // The clear bit lives one cycle only, so software sees it read back as zero
  always_ff @(posedge ref_clk) begin
    if (sfr_clr) begin
      auxa_reg <= '0;
    end else if (wr_auxa) begin
      auxa_reg <= bus.wdata;
    end else begin
      auxa_reg[`RCC_WDT_CLR] <= 1'b0;
    end
  end
  // Wakeup beats a same-cycle write so a pending wake is never lost
  always_ff @(posedge ref_clk) begin
    if (sfr_clr || wakeup) begin
      pwr_reg <= '0;
    end else if (wr_pwr) begin
      pwr_reg <= bus.wdata & `RCC_PWR_MASK;
    end
  end
  // Detection set wins over the clear key
  always_ff @(posedge ref_clk) begin
    if (sfr_clr) begin
      lvd_flag_reg <= 1'b0;
    end else if (low_voltage_detect) begin
      lvd_flag_reg <= 1'b1;
    end else if (wr_iflg && bus.wdata == `RCC_LVD_KEY) begin
      lvd_flag_reg <= 1'b0;
    end
  end
  // ****************************************
  // System clock prescaler
  // ****************************************
  wire [1:0] osc_sel = {cc_reg.fast_sel, cc_reg.fast_sel ? cc_reg.fast_type : cc_reg.slow_type};
  wire base_tick = osc_tick[osc_sel] && !pd;
  wire [3:0] pre_last = eff_div_reg == 2'h0 ? 4'hF : eff_div_reg == 2'h1 ? 4'h3 :
                        eff_div_reg == 2'h2 ? 4'h1 : 4'h0;
  wire pre_wrap = base_tick && pre_reg >= pre_last;
  // New divide applies at wrap, bounding the latency to 16 source ticks
  always_ff @(posedge ref_clk) begin
    if (sfr_clr) begin
      pre_reg <= '0;
      eff_div_reg <= cc_reg.div;
    end else if (pre_wrap) begin
      pre_reg <= '0;
      eff_div_reg <= cc_reg.div;
    end else if (base_tick) begin
      pre_reg <= pre_reg + 1'b1;
    end
  end
  // ****************************************
  // Registered outputs
  // ****************************************
  wire [7:0] rd_mux =
    bus.addr == `RCC_A_PWR ? pwr_reg :
    bus.addr == `RCC_A_OPT ? opt_reg :
    bus.addr == `RCC_A_IFLG ? {lvd_flag_reg, 7'h00} :
    bus.addr == `RCC_A_SYSTEM_CLOCK_CONTROL ? cc_reg :
    bus.addr == `RCC_A_TRIM ? {1'b0, trim_reg} :
    bus.addr == `RCC_A_AUXB ? auxb_reg :
    bus.addr == `RCC_A_AUXA ? auxa_reg :
    bus.addr == `RCC_A_CFGH ? cfg_reg : 8'h00;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_reg <= '0;
      sys_rst_reg <= 1'b1;
      sys_en_reg <= 1'b0;
      per_en_reg <= 1'b0;
      fast_on_reg <= 1'b1;
      slow_on_reg <= 1'b1;
      lvr_on_reg <= 1'b1;
    end else begin
      rd_reg <= bus.rd ? rd_mux : 8'h00;
      sys_rst_reg <= !run || src_hit;
      sys_en_reg <= pre_wrap && run;
      per_en_reg <= pre_wrap && run && !(idl && cc_reg.periph_stop);
      fast_on_reg <= !cc_reg.fast_stop && !pd;
      slow_on_reg <= slow_alive;
      lvr_on_reg <= lvr_live;
    end
  end
  assign rdata = rd_reg;
  assign sys_reset = sys_rst_reg;
  assign sys_clk_en = sys_en_reg;
  assign periph_clk_en = per_en_reg;
  assign fast_osc_on = fast_on_reg;
  assign slow_osc_on = slow_on_reg;
  assign clk_cfg = cc_reg;
  assign fast_rc_trim_value = trim_reg;
  assign low_voltage_reset_on = lvr_on_reg;
  assign low_voltage_reset_level = cfg_reg[`RCC_CFG_LVR];
  assign idle_mode = pwr_reg[`RCC_IDL];
  assign power_down_request = pwr_reg[`RCC_PD];
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_warm_reset_held: assert property (state_reg != RCC_RUN |=> sys_reset)
    else $error("reset not held during warm-up");
  a_sw_key_reset: assert property (run && sw_hit |=> sys_reset ##1 clk_cfg == `RCC_SYSTEM_CLOCK_CONTROL_RST)
    else $error("software key did not reset");
  a_lvd_flag_set: assert property (run && low_voltage_detect |=> lvd_flag_reg)
    else $error("detect flag not set");
  a_lvd_flag_clr: assert property (run && !rst_evt_reg && wr_iflg
    && bus.wdata == `RCC_LVD_KEY && !low_voltage_detect |=> !lvd_flag_reg)
    else $error("detect flag not cleared");
  a_never_stop_sel: assert property (!(clk_cfg.fast_stop && clk_cfg.fast_sel))
    else $error("fast stop with fast select");
  a_slow_type_lock: assert property (!cc_reg.fast_sel && !sfr_clr
    |=> $stable(cc_reg.slow_type) || sfr_clr)
    else $error("slow type changed in slow mode");
  a_fast_type_lock: assert property (cc_reg.fast_sel && !sfr_clr
    |=> $stable(cc_reg.fast_type) || sfr_clr)
    else $error("fast type changed in fast mode");
  a_wdt_clear_bit: assert property (auxa_reg[`RCC_WDT_CLR]
    |=> !auxa_reg[`RCC_WDT_CLR] && wdt_reg == '0)
    else $error("watchdog clear not honoured");
  // Watches the reset output itself, so a broken pin gate shows up here
  a_pin_reset_off: assert property (run && cfg_reg[`RCC_CFG_PINDIS] && !ext_reset_n
    && !sw_hit && !lv_hit && !wdt_hit |=> !sys_reset)
    else $error("disabled pin reset acted");
  c_sw_reset: cover property (run && sw_hit);
  c_fast_switch: cover property (run && $rose(cc_reg.fast_sel));
  c_wdt_overflow: cover property (run && wdt_hit);
endmodule // rcc_reset_clock_ctrl

//--- rcc_far_side_model.sv
// ****************************************
// Pin and boot memory side of the block
// ****************************************
module rcc_far_side_model (
  input wire logic ref_clk,
  output logic ext_reset_n,
  output logic [7:0] boot_config_high_byte,
  output logic [6:0] trim_cal
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    ext_reset_n = 1'b1;
    trim_cal = 7'h5A;
  end
  // Only sampled in the load cycle, so the value may change at any time before it
  task automatic cfg_set(input logic [7:0] v);
    boot_config_high_byte <= v;
  endtask
  // Level changes land just after an edge; the caller owns the hold time
  task automatic pin_set(input logic v);
    @(posedge ref_clk);
    ext_reset_n <= v;
  endtask
endmodule // rcc_far_side_model

//--- reset_and_clock_control_tb_top.sv
// ****************************************
// Bench top
// ****************************************
module reset_and_clock_control_tb_top;
  import rcc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WARM = 20;
  localparam int SLOW = 1562;
  localparam int FAST_INTERNAL_RC = 6;
  localparam int FAST_CRYSTAL = 7;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  rcc_bus_s bus = '0;
  logic lv_trip = 1'b0;
  logic lv_det = 1'b0;
  logic wake = 1'b0;
  logic [7:0] rdata;
  logic ext_reset_n, sys_reset, sys_clk_en, lvr_on, idle, pdr;
  logic per_en, fast_on, slow_on;
  logic [7:0] cfg;
  logic [6:0] trim, trim_out;
  logic [2:0] lvl;
  rcc_system_clock_control_s clk_cfg;
  int n_errors = 0;
  int comparisons = 0;
  logic [7:0] v;
  int t;
  logic [7:0] tab [10][2] = '{'{8'hA3, 8'h23}, '{8'h63, 8'h63}, '{8'h23, 8'h23},
    '{8'h2F, 8'h23}, '{8'h2B, 8'h2B}, '{8'h27, 8'h23}, '{8'h27, 8'h27},
    '{8'hA7, 8'hA7}, '{8'hE7, 8'hA7}, '{8'h2B, 8'h23}};
  int divs [4] = '{16, 4, 2, 1};
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  rcc_far_side_model i_rcc_far_side_model (.ref_clk(ref_clk), .ext_reset_n(ext_reset_n),
    .boot_config_high_byte(cfg), .trim_cal(trim));
  rcc_reset_clock_ctrl #(.WARM_CYC(WARM)) i_rcc_reset_clock_ctrl (.ref_clk(ref_clk),
    .rst(rst), .bus(bus), .rdata(rdata), .ext_reset_n(ext_reset_n),
    .low_voltage_trip(lv_trip), .low_voltage_detect(lv_det), .wakeup(wake),
    .boot_config_high_byte(cfg), .trim_cal(trim), .sys_reset(sys_reset),
    .sys_clk_en(sys_clk_en), .periph_clk_en(per_en), .fast_osc_on(fast_on),
    .slow_osc_on(slow_on),
    .clk_cfg(clk_cfg), .fast_rc_trim_value(trim_out), .low_voltage_reset_on(lvr_on),
    .low_voltage_reset_level(lvl), .idle_mode(idle), .power_down_request(pdr));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic give_verdict();
    if (n_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
    // Return past the taking edge so callers see what the write launched
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic wait_rst(input logic lv, input int lim, output int n);
    for (n = 0; n < lim; n++) begin
      @(posedge ref_clk);
      #1;
      if (sys_reset === lv) return;
    end
    n_errors++;
    $display("[FAIL] %0t wait for system reset ran out", $time);
    give_verdict();
  endtask
  task automatic wait_tick(output int n);
    for (n = 1; n < 400; n++) begin
      @(posedge ref_clk);
      #1;
      if (sys_clk_en === 1'b1) return;
    end
    n_errors++;
    $display("[FAIL] %0t no clock enable pulse", $time);
    give_verdict();
  endtask
  task automatic do_por(input logic [7:0] c);
    i_rcc_far_side_model.cfg_set(c);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    wait_rst(1'b0, 200, t);
    check(8'(t >= WARM && t <= WARM + 4), 8'h01);
  endtask
  // Pin held low for n cycles, sampled before release
  task automatic pin_low(input int n, input logic exp);
    i_rcc_far_side_model.pin_set(1'b0);
    repeat (n) @(posedge ref_clk);
    #1;
    check(8'(sys_reset), 8'(exp));
    i_rcc_far_side_model.pin_set(1'b1);
    if (exp) wait_rst(1'b0, 50, t);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    do_por(8'h28);
    check(8'(trim_out), 8'h5A);
    check(8'(lvl), 8'h05);
    check(clk_cfg, 8'h23);
    check(8'(fast_on), 8'h01);
    check(8'(slow_on), 8'h01);
    check(8'(idle), 8'h00);
    rd(16'h00F6, v); check(v, 8'h5A);
    rd(16'h00F7, v); check(v, 8'h00);
    wr(16'h7FFF, 8'hFF);
    rd(16'h7FFF, v); check(v, 8'h28);
    rd(16'h0090, v); check(v, 8'h00);
    rd(16'h0097, v); check(v, 8'h00);
    wr(16'h0094, 8'hFF);
    rd(16'h0094, v); check(v, 8'hBF);
    for (int i = 0; i < 10; i++) begin
      wr(16'h00D8, tab[i][0]);
      rd(16'h00D8, v); check(v, tab[i][1]);
    end
    wr(16'h00D8, 8'h27);
    for (int i = 0; i < 4; i++) begin
      wr(16'h00D8, 8'h24 | 8'(i));
      repeat (120) @(posedge ref_clk);
      wait_tick(t);
      wait_tick(t);
      check(8'(t), 8'(FAST_INTERNAL_RC * divs[i]));
      check(8'(per_en), 8'h01);
    end
    wr(16'h00D8, 8'h23);
    wr(16'h00D8, 8'h63);
    // A real crystal needs about 2 ms to settle; the bench oscillator is ready at once
    repeat (20) @(posedge ref_clk);
    wr(16'h00D8, 8'h67);
    wait_tick(t);
    wait_tick(t);
    check(8'(t), 8'(FAST_CRYSTAL));
    wr(16'h00D8, 8'h37);
    wr(16'h0087, 8'h01);
    check(8'(idle), 8'h01);
    wait_tick(t);
    check(8'(per_en), 8'h00);
    wr(16'h0087, 8'h02);
    check(8'(pdr), 8'h01);
    @(posedge ref_clk);
    #1;
    check(8'(fast_on), 8'h00);
    check(8'(slow_on), 8'h00);
    @(posedge ref_clk);
    wake <= 1'b1;
    @(posedge ref_clk);
    wake <= 1'b0;
    #1;
    check(8'(pdr), 8'h00);
    @(posedge ref_clk);
    lv_det <= 1'b1;
    @(posedge ref_clk);
    lv_det <= 1'b0;
    rd(16'h0095, v); check(v, 8'h80);
    wr(16'h0095, 8'hFF);
    rd(16'h0095, v); check(v, 8'h80);
    wr(16'h0095, 8'h7F);
    rd(16'h0095, v); check(v, 8'h00);
    wr(16'h00F8, 8'h80);
    rd(16'h00F8, v); check(v, 8'h00);
    wr(16'h00F8, 8'h08);
    @(posedge ref_clk);
    #1;
    check(8'(lvr_on), 8'h00);
    @(posedge ref_clk);
    lv_trip <= 1'b1;
    repeat (20) @(posedge ref_clk);
    check(8'(sys_reset), 8'h00);
    lv_trip <= 1'b0;
    wr(16'h00F7, 8'hC0);
    rd(16'h00F7, v); check(v, 8'hC0);
    wr(16'h00F8, 8'h00);
    @(posedge ref_clk);
    #1;
    check(8'(lvr_on), 8'h01);
    lv_trip <= 1'b1;
    wait_rst(1'b1, 8, t);
    lv_trip <= 1'b0;
    wait_rst(1'b0, 50, t);
    check(8'(trim_out), 8'h5A);
    rd(16'h00F7, v); check(v, 8'h00);
    wr(16'h00D8, 8'h27);
    wr(16'h0097, 8'h55);
    check(8'(sys_reset), 8'h00);
    wr(16'h0097, 8'h56);
    check(8'(sys_reset), 8'h01);
    wait_rst(1'b0, 50, t);
    check(clk_cfg, 8'h23);
    pin_low(1000, 1'b0);
    pin_low(2 * SLOW + 200, 1'b1);
    do_por(8'h40);
    check(8'(lvl), 8'h00);
    pin_low(2 * SLOW + 200, 1'b0);
    give_verdict();
  end
endmodule // reset_and_clock_control_tb_top
